// [shared/frs_pkg.sv]
// Purpose: constants for the serial memory slave
// Assumes: 125 MHz system clock
// Notes:   address byte layout and timing figures
package frs_pkg;
  // Address byte fields
  localparam logic [3:0] FAMILY_ID_DEF  = 4'h5;  // Arbitrary value
  localparam int         ID_MSB         = 7;
  localparam int         ID_LSB         = 4;
  localparam int         DEVSEL_MSB     = 3;
  localparam int         DEVSEL_LSB     = 2;
  localparam int         PAGE_BIT       = 1;
  localparam int         RW_BIT         = 0;
  // Master code for high-speed entry
  localparam logic [4:0] HS_CODE        = 5'h01;
  // Memory size
  localparam int         MEM_AW         = 17;
  localparam int         MEM_WORDS      = 131072;
  // Timing
  localparam int         CLK_MHZ        = 125;
  localparam int         HS_KHZ         = 3400;
  localparam int         HS_HALF_CYC    = (CLK_MHZ * 1000) / (HS_KHZ * 2);
  localparam int         FIFO_DEPTH     = 16;
  typedef enum logic [2:0] {
    FRS_IDLE, FRS_DEVADDR, FRS_ACK, FRS_ADDR_HI, FRS_ADDR_LO, FRS_WDATA,
    FRS_RDATA, FRS_RACK
  } frs_state_t;
endpackage

// [core/frs_fifo.sv]
// Purpose: small write-data buffer
// Assumes: single clock
// Notes:   first-word-fall-through, honest full and empty
`timescale 1ns/1ps
module frs_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshake terms
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [core/frs_slave.sv]
// Purpose: I2C slave of a 1 Mb ferroelectric memory with Hs-mode
// Assumes: scl and sda are pins, sampled through three flip-flops
// Notes:   writes pass a 16-word buffer before reaching the array
`timescale 1ns/1ps
// How it works
// - Address byte: family, device select, page
// - Device select must match strap pins
// - Page bit picks one 64 KB page
// - One megabit array, page plus address
// - Two straps give four bus addresses
// - Master code 00001XXX enters high-speed mode
// - Runs correctly up to 3.4 MHz
// - STOP leaves high-speed mode
// - Single and multi byte transfers in Hs
// - Pure slave, many masters share bus
// - Write bytes to successive locations, acked
// - Current reads use the pointer, one past the last byte accessed, with the page bit from the address byte
// - Selective read data starts next clock
module frs_slave #(
  parameter logic [3:0] FAMILY_ID = frs_pkg::FAMILY_ID_DEF
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Strap pins
  input  wire logic addr_strap_high,
  input  wire logic addr_strap_mid,
  // Bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Status
  output logic      hs_mode
);
  localparam int AW = frs_pkg::MEM_AW;
  logic [7:0] mem [frs_pkg::MEM_WORDS];

  // Pin synchronisers
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic       scl_r;
  logic       sda_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_r   <= 1'b1;
      sda_r   <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_r <= sda_s_r[2];
      end
    end
  end
  logic scl_q_r;
  logic sda_q_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_r;
      sda_q_r <= sda_r;
    end
  end
  // Bus events; sampling at 125 MHz covers 3.4 MHz Hs timing
  assign scl_rise = scl_r && !scl_q_r;
  assign scl_fall = !scl_r && scl_q_r;
  assign start_ev = scl_r && scl_q_r && sda_q_r && !sda_r;
  assign stop_ev  = scl_r && scl_q_r && !sda_q_r && sda_r;

  // Protocol state
  frs_pkg::frs_state_t state_r;
  frs_pkg::frs_state_t after_ack_r;
  logic [7:0]    shift_r;
  logic [3:0]    bitcnt_r;
  logic          rw_r;
  logic [AW-1:0] ptr_r;
  logic [7:0]    addr_hi_r;
  logic          hs_r;
  logic          sel_ok;
  logic          is_hs_code;
  logic [7:0]    rd_byte_r;

  // Address byte decode, R/W in bit 0
  assign sel_ok = (shift_r[frs_pkg::ID_MSB:frs_pkg::ID_LSB] == FAMILY_ID)
    && (shift_r[frs_pkg::DEVSEL_MSB:frs_pkg::DEVSEL_LSB]
        == {addr_strap_high, addr_strap_mid});
  assign is_hs_code = (shift_r[7:3] == frs_pkg::HS_CODE);

  // Write buffer: page/address plus data
  logic          wq_valid;
  logic          wq_ready;
  logic          wq_out_valid;
  logic [AW+7:0] wq_out_data;
  logic [AW+7:0] wq_in_data;
  frs_fifo #(
    .WIDTH (AW+8),
    .DEPTH (frs_pkg::FIFO_DEPTH)
  ) u_wq (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (wq_valid),
    .in_ready  (wq_ready),
    .in_data   (wq_in_data),
    .out_valid (wq_out_valid),
    .out_ready (1'b1),
    .out_data  (wq_out_data)
  );

  // Array write from buffer drain
  always_ff @(posedge clock) begin
    if (wq_out_valid) begin
      mem[wq_out_data[AW+7:8]] <= wq_out_data[7:0];
    end
  end
  // Array read of the pointed byte
  always_ff @(posedge clock) begin
    rd_byte_r <= mem[ptr_r];
  end

  // Data byte completes on eighth rising edge
  assign wq_valid   = (state_r == frs_pkg::FRS_WDATA) && scl_rise
                      && (bitcnt_r == 4'h7);
  assign wq_in_data = {ptr_r, shift_r[6:0], sda_r};

  // Shift register and bit count; the ninth (ack) rise wraps to 0
  always_ff @(posedge clock) begin
    if (rst || start_ev) begin
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
    end else if (scl_rise) begin
      shift_r  <= {shift_r[6:0], sda_r};
      bitcnt_r <= (bitcnt_r == 4'h8) ? 4'h0 : bitcnt_r + 4'h1;
    end
  end

  // High-speed mode flag; the bus goes back on STOP
  always_ff @(posedge clock) begin
    if (rst || stop_ev) begin
      hs_r <= 1'b0;
    end else if (state_r == frs_pkg::FRS_DEVADDR && scl_fall
                 && bitcnt_r == 4'h8 && is_hs_code) begin
      hs_r <= 1'b1;
    end
  end
  assign hs_mode = hs_r;

  // Main sequencer; never drives SCL, only slave SDA
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r     <= frs_pkg::FRS_IDLE;
      after_ack_r <= frs_pkg::FRS_IDLE;
      rw_r        <= 1'b0;
      ptr_r       <= '0;
      addr_hi_r   <= 8'h00;
      sda_out     <= 1'b1;
      sda_oe      <= 1'b0;
    end else if (stop_ev) begin
      state_r <= frs_pkg::FRS_IDLE;
      sda_oe  <= 1'b0;
    end else if (start_ev) begin
      state_r <= frs_pkg::FRS_DEVADDR;
      sda_oe  <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_r)
        frs_pkg::FRS_IDLE: begin
          sda_oe <= 1'b0;
        end
        frs_pkg::FRS_DEVADDR: begin
          if (bitcnt_r == 4'h8) begin
            if (sel_ok) begin
              rw_r     <= shift_r[frs_pkg::RW_BIT];
              ptr_r[AW-1] <= shift_r[frs_pkg::PAGE_BIT];
              sda_out  <= 1'b0;
              sda_oe   <= 1'b1;
              state_r  <= frs_pkg::FRS_ACK;
              after_ack_r <= shift_r[frs_pkg::RW_BIT]
                ? frs_pkg::FRS_RDATA
                : frs_pkg::FRS_ADDR_HI;
            end else begin
              state_r <= frs_pkg::FRS_IDLE;  // Hs code is not acked
            end
          end
        end
        frs_pkg::FRS_ADDR_HI, frs_pkg::FRS_ADDR_LO,
        frs_pkg::FRS_WDATA: begin
          if (bitcnt_r == 4'h8) begin
            if (state_r == frs_pkg::FRS_ADDR_HI) begin
              addr_hi_r   <= shift_r;
              after_ack_r <= frs_pkg::FRS_ADDR_LO;
            end else if (state_r == frs_pkg::FRS_ADDR_LO) begin
              ptr_r[15:0] <= {addr_hi_r, shift_r};
              after_ack_r <= frs_pkg::FRS_WDATA;
            end else begin
              ptr_r       <= ptr_r + 1'b1;
              after_ack_r <= frs_pkg::FRS_WDATA;
            end
            // Full buffer withholds the acknowledge
            sda_out <= !wq_ready && state_r == frs_pkg::FRS_WDATA;
            sda_oe  <= 1'b1;
            state_r <= frs_pkg::FRS_ACK;
          end
        end
        frs_pkg::FRS_ACK: begin
          if (after_ack_r == frs_pkg::FRS_RDATA) begin
            sda_out <= rd_byte_r[7];
            sda_oe  <= 1'b1;
          end else begin
            sda_oe  <= 1'b0;
          end
          state_r <= after_ack_r;
        end
        frs_pkg::FRS_RDATA: begin
          if (bitcnt_r == 4'h8) begin
            sda_oe  <= 1'b0;
            ptr_r   <= ptr_r + 1'b1;
            state_r <= frs_pkg::FRS_RACK;
          end else begin
            sda_out <= rd_byte_r[3'(7 - bitcnt_r)];
          end
        end
        frs_pkg::FRS_RACK: begin
          // Master ACK continues the read, NACK ends it
          if (!shift_r[0]) begin
            sda_out <= rd_byte_r[7];
            sda_oe  <= 1'b1;
            state_r <= frs_pkg::FRS_RDATA;
          end else begin
            state_r <= frs_pkg::FRS_IDLE;
          end
        end
      endcase
    end
  end

  // Assertions; byte-end steps are named sequences
  sequence s_addr_done;
    state_r == frs_pkg::FRS_DEVADDR && scl_fall && bitcnt_r == 4'h8;
  endsequence
  sequence s_rd_done;
    state_r == frs_pkg::FRS_RDATA && scl_fall && bitcnt_r == 4'h8;
  endsequence
  sequence s_ack_to_read;
    state_r == frs_pkg::FRS_ACK && scl_fall
      && after_ack_r == frs_pkg::FRS_RDATA;
  endsequence
  a_hs_exit_stop: assert property (
    @(posedge clock) disable iff (rst) stop_ev |=> !hs_mode)
    else $error("hs mode kept after stop");
  a_no_ack_foreign: assert property (
    @(posedge clock) disable iff (rst)
    s_addr_done ##0 !sel_ok |=> !sda_oe)
    else $error("acked a foreign address");
  a_ack_family: assert property (
    @(posedge clock) disable iff (rst)
    s_addr_done ##0 sel_ok |=> (sda_oe && !sda_out))
    else $error("own address not acked");
  a_hs_entry: assert property (
    @(posedge clock) disable iff (rst)
    s_addr_done ##0 is_hs_code |=> hs_mode)
    else $error("master code ignored");
  a_ptr_step: assert property (
    @(posedge clock) disable iff (rst)
    s_rd_done |=> ptr_r == $past(ptr_r) + 1'b1)
    else $error("pointer did not advance");
  a_page_bit: assert property (
    @(posedge clock) disable iff (rst)
    s_addr_done ##0 sel_ok
    |=> ptr_r[AW-1] == $past(shift_r[frs_pkg::PAGE_BIT]))
    else $error("page bit not taken");
  a_write_queue: assert property (
    @(posedge clock) disable iff (rst)
    wq_valid && wq_ready |=> wq_out_valid)
    else $error("write byte lost");
  a_read_drive: assert property (
    @(posedge clock) disable iff (rst)
    s_ack_to_read |=> sda_oe && sda_out == $past(rd_byte_r[7]))
    else $error("read data not driven");
  a_ack_slot: assert property (
    @(posedge clock) disable iff (rst)
    (state_r == frs_pkg::FRS_ACK || state_r == frs_pkg::FRS_RACK)
    && scl_rise |=> bitcnt_r == 4'h0)
    else $error("ack slot not closing the byte");
  a_slave_only: assert property (
    @(posedge clock) disable iff (rst)
    state_r == frs_pkg::FRS_IDLE && !scl_fall |=> !sda_oe || scl_fall)
    else $error("drove bus while idle");
endmodule

// [sim/frs_mst_model.sv]
// Purpose: bus master model driving SCL and pulling SDA low
// Assumes: open-drain SDA with pull-up resolved by the bench
// Notes:   quarter-bit of Q clocks, 3.125 MHz bit rate at 125 MHz
`timescale 1ns/1ps
module frs_mst_model #(
  parameter int Q = 10
) (
  // Clock
  input  wire logic clock,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  logic r;

  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Wait n quarter bits, changes land off the rising edge
  task automatic q(input int n);
    repeat (n * Q) @(negedge clock);
  endtask

  // Start or repeated start; only this model drives SCL
  task automatic start();
    q(1);
    sda_pull = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b1;
    q(1);
    scl = 1'b0;
  endtask

  // Stop condition
  task automatic stop();
    q(1);
    sda_pull = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b0;
    q(1);
  endtask

  // One bit: data set mid-low, sampled mid-high
  task automatic sbit(input logic b);
    q(1);
    sda_pull = !b;
    q(1);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl = 1'b0;
  endtask

  // Byte out MSB first, then the slave's acknowledge bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) sbit(d[i]);
    sbit(1'b1);
    ack = !r;
  endtask

  // Byte in MSB first, then master acknowledge unless last
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      sbit(1'b1);
      d[i] = r;
    end
    sbit(last);
  endtask
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the serial memory slave
// Assumes: master model owns the bus, straps driven by the bench
// Notes:   reset checks first, then address table loop, then memory and Hs tests
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] FID = frs_pkg::FAMILY_ID_DEF;
  typedef struct packed {
    logic [1:0] strap;
    logic [1:0] sel;
    logic [3:0] id;
    logic       ack;
  } frs_row_t;
  logic       clock, rst, st_hi, st_mid, scl, pull, a;
  logic       sda_out, sda_oe, hs_mode;
  wire logic  sda;
  logic [7:0] d;
  int         err_total, n_tests;
  frs_row_t   rows [6];

  // Open-drain data line with pull-up
  assign sda = !(pull || (sda_oe && !sda_out));

  frs_slave i_frs_slave (.clock(clock), .rst(rst),
    .addr_strap_high(st_hi), .addr_strap_mid(st_mid), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .hs_mode(hs_mode));
  frs_mst_model i_frs_mst_model (.clock(clock), .sda(sda), .scl(scl),
    .sda_pull(pull));

  // Clock of 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compare tasks and closing report
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bus helpers built on the master model
  task automatic sta();
    i_frs_mst_model.start();
  endtask
  task automatic sto();
    i_frs_mst_model.stop();
    repeat (10) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] v);
    i_frs_mst_model.wbyte(v, a);
    chk_bit(a, 1'b1, "byte not acked");
  endtask
  function automatic logic [7:0] ab(input logic p, input logic rw);
    return {FID, st_hi, st_mid, p, rw};
  endfunction
  task automatic setp(input logic p, input logic [15:0] m);
    sta();
    wr(ab(p, 1'b0));
    wr(m[15:8]);
    wr(m[7:0]);
  endtask
  task automatic rd(input logic last, input logic [7:0] e);
    i_frs_mst_model.rbyte(last, d);
    chk_byte(d, e);
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    st_hi = 1'b0;
    st_mid = 1'b0;
    err_total = 0;
    n_tests = 0;
    rows = '{'{2'h0, 2'h0, FID, 1'b1}, '{2'h1, 2'h1, FID, 1'b1},
             '{2'h2, 2'h2, FID, 1'b1}, '{2'h3, 2'h3, FID, 1'b1},
             '{2'h2, 2'h1, FID, 1'b0}, '{2'h3, 2'h3, FID ^ 4'h1, 1'b0}};
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    chk_bit(sda_oe, 1'b0, "drives after reset");
    chk_bit(hs_mode, 1'b0, "hs after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      {st_hi, st_mid} = rows[i].strap;
      repeat (4) @(negedge clock);
      sta();
      i_frs_mst_model.wbyte({rows[i].id, rows[i].sel, i[0], 1'b0}, a);
      chk_bit(a, rows[i].ack, "address ack");
      sto();
    end
    $display("test address done");
    // Page 1 top wraps to the array start
    setp(1'b1, 16'hFFFF);
    wr(8'hA5);
    wr(8'h5A);
    sto();
    setp(1'b1, 16'hFFFF);
    sta();
    wr(ab(1'b1, 1'b1));
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'h5A);
    sto();
    $display("test wrap done");
    // Same offset in both pages, then a current read
    setp(1'b0, 16'h1234);
    wr(8'hC3);
    sto();
    setp(1'b1, 16'h1234);
    wr(8'h69);
    wr(8'h96);
    sto();
    setp(1'b1, 16'h1234);
    sta();
    wr(ab(1'b1, 1'b1));
    rd(1'b1, 8'h69);
    sto();
    sta();
    wr(ab(1'b1, 1'b1));
    rd(1'b1, 8'h96);
    sto();
    setp(1'b0, 16'h1234);
    sta();
    wr(ab(1'b0, 1'b1));
    rd(1'b1, 8'hC3);
    sto();
    $display("test pages done");
    // Master code, Hs multi-byte traffic, stop leaves Hs
    sta();
    i_frs_mst_model.wbyte(8'h0D, a);
    chk_bit(a, 1'b0, "master code acked");
    repeat (8) @(negedge clock);
    chk_bit(hs_mode, 1'b1, "hs not entered");
    setp(1'b0, 16'h0100);
    wr(8'h11);
    wr(8'h22);
    setp(1'b0, 16'h0100);
    sta();
    wr(ab(1'b0, 1'b1));
    rd(1'b0, 8'h11);
    rd(1'b1, 8'h22);
    chk_bit(hs_mode, 1'b1, "hs lost early");
    sto();
    chk_bit(hs_mode, 1'b0, "hs kept after stop");
    $display("test hs done");
    // Reset in mid-run drops Hs mode; array keeps its data
    sta();
    i_frs_mst_model.wbyte(8'h0F, a);
    chk_bit(a, 1'b0, "master code acked");
    repeat (8) @(negedge clock);
    chk_bit(hs_mode, 1'b1, "hs not entered");
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    chk_bit(hs_mode, 1'b0, "hs kept in reset");
    chk_bit(sda_oe, 1'b0, "drives in reset");
    sto();
    setp(1'b0, 16'h0100);
    sta();
    wr(ab(1'b0, 1'b1));
    rd(1'b1, 8'h11);
    sto();
    $display("test mid reset done");
    end_sim();
  end
endmodule
